/* core/rxt_pkg.sv */
// Package: register map, field layout, reset values and types of the block
package rxt_pkg;

	// Register indices; the byte address is four times the index
	localparam logic [7:0] IDX_DEVIATION  = 8'h15;
	localparam logic [7:0] IDX_RX_TIMEOUT = 8'h16;
	localparam logic [7:0] IDX_PACKET_END = 8'h17;
	localparam logic [7:0] IDX_RADIO_CFG  = 8'h40;
	localparam logic [7:0] IDX_STATUS     = 8'h41;

	// Field positions inside the register words
	localparam int RXT_RSSI_POS  = 4;
	localparam int RXT_QUAL_POS  = 3;
	localparam int RXT_TIME_POS  = 0;
	localparam int PE_CCA_POS    = 4;
	localparam int PE_RXOFF_POS  = 2;
	localparam int PE_TXOFF_POS  = 0;
	localparam int DEV_E_POS     = 4;
	localparam int DEV_M_POS     = 0;
	localparam int CFG_EVENT_POS = 0;
	localparam int CFG_RES_POS   = 16;
	localparam int CFG_MOD_POS   = 20;
	localparam int ST_STATE_POS  = 0;
	localparam int ST_CCA_POS    = 4;
	localparam int ST_CS_POS     = 5;
	localparam int ST_SYNC_POS   = 6;
	localparam int ST_TOUT_POS   = 7;

	// Reset values
	localparam logic [2:0]  RX_TIME_RST = 3'h7;
	localparam logic [1:0]  CCA_RST     = 2'h3;
	localparam logic [1:0]  RXOFF_RST   = 2'h0;
	localparam logic [1:0]  TXOFF_RST   = 2'h0;
	localparam logic [2:0]  DEV_E_RST   = 3'h4;
	localparam logic [2:0]  DEV_M_RST   = 3'h7;
	localparam logic [15:0] EVENT_RST   = 16'h8000;
	localparam logic [1:0]  RES_RST     = 2'h0;

	// Timeout constants and bus word size
	localparam logic [2:0] RX_TIME_OFF = 3'h7;
	localparam logic [3:0] ASK_SYMBOLS = 4'h8;
	localparam logic [3:0] EVENT_DROP  = 4'h3;
	localparam logic [2:0] HSIZE_WORD  = 3'h2;

	typedef enum logic [1:0] {ST_IDLE, ST_SYNTH_ON_READY_STATE, ST_TX, ST_RX} rxt_state_e;
	typedef enum logic [1:0] {MOD_2FSK, MOD_GFSK, MOD_ASK, MOD_MSK} rxt_mod_e;

	typedef struct packed {
		logic       carrier_sense_rx_end;
		logic       timeout_quality_check;
		logic [2:0] rx_time;
		logic [1:0] clear_channel_select;
		logic [1:0] after_receive_state;
		logic [1:0] after_transmit_state;
		logic [2:0] dev_e;
		logic [2:0] dev_m;
		logic [15:0] wake_event_period;
		logic [1:0] wake_timer_resolution;
		rxt_mod_e   modulation;
	} rxt_cfg_s;

	localparam rxt_cfg_s CFG_RST = '{1'b0, 1'b0, RX_TIME_RST, CCA_RST,
		RXOFF_RST, TXOFF_RST, DEV_E_RST, DEV_M_RST, EVENT_RST, RES_RST,
		MOD_2FSK};

	typedef struct packed {
		logic rx_start;
		logic tx_start;
		logic idle_cmd;
		logic pkt_rx_done;
		logic pkt_tx_done;
		logic sync_found;
		logic preamble_quality_flag;
		logic carrier_sense;
		logic receiving_pkt;
		logic symbol_tick;
		logic rc_tick;
	} rxt_radio_in_s;

	typedef struct packed {
		rxt_cfg_s   cfg;
		rxt_state_e rstate;
		logic       dp_wr;
		logic       dp_rd;
		logic [7:0] dp_idx;
		logic [31:0] hrdata;
		logic       ready;
		logic [3:0] sym_cnt;
		logic       cs_seen;
		logic       sync_seen;
		logic       tout_seen;
		logic       rx_end;
		logic       nxt_valid;
		logic       cca;
		logic       dev_active;
	} rxt_core_s;

endpackage : rxt_pkg

/* core/rxt_rx_timer.sv */
// Sync-search timeout counter running on RC oscillator ticks
`timescale 1ns/1ps
module rxt_rx_timer #(
	parameter int EVENT_W = 16
) (
	input  wire logic               core_clk_in,
	input  wire logic               resetn_in,
	input  wire logic               start_in,
	input  wire logic               run_in,
	input  wire logic               rc_tick_in,
	input  wire logic [EVENT_W-1:0] event_period_in,
	input  wire logic [2:0]         rx_time_in,
	input  wire logic [1:0]         res_in,
	output logic                    expire_out
);

	typedef struct packed {
		logic [EVENT_W-1:0] cnt;
		logic [EVENT_W-1:0] tgt;
		logic [3:0]         pre;
		logic [3:0]         lim;
		logic               active;
		logic               expire;
		logic [31:0]        ticks;
	} rxt_timer_s;

	rxt_timer_s s_ff, nxt_s;

	if (EVENT_W < 10) begin : g_bad_width
		$error("EVENT_W too small for the timeout shift");
	end

	// RC periods per count unit grow with the wake timer resolution
	function automatic logic [3:0] unit_len(input logic [1:0] res);
		unit_len = 4'h1 + {res, 2'b00};
	endfunction : unit_len

	// R7: drop LSBs per step
	// R4: scaled event period
	always_comb begin
		nxt_s = s_ff;
		nxt_s.expire = 1'b0;
		if (!run_in)
			nxt_s.active = 1'b0;
		if (start_in) begin
			nxt_s.cnt = '0;
			nxt_s.pre = 4'h0;
			nxt_s.ticks = 32'h0;
			nxt_s.tgt = event_period_in >>
				(rxt_pkg::EVENT_DROP + {1'b0, rx_time_in});
			nxt_s.lim = unit_len(res_in);
			// R3: setting 7 disables
			nxt_s.active = (rx_time_in != rxt_pkg::RX_TIME_OFF);
		end else if (s_ff.active && run_in && rc_tick_in) begin
			// Tick count kept only for the span check
			nxt_s.ticks = s_ff.ticks + 32'h1;
			if (s_ff.pre == s_ff.lim - 4'h1) begin
				nxt_s.pre = 4'h0;
				if (s_ff.cnt + 1'b1 >= s_ff.tgt) begin
					nxt_s.expire = 1'b1;
					nxt_s.active = 1'b0;
				end else begin
					nxt_s.cnt = s_ff.cnt + 1'b1;
				end
			end else begin
				nxt_s.pre = s_ff.pre + 4'h1;
			end
		end
	end

	// State register
	always_ff @(posedge core_clk_in or negedge resetn_in) begin
		if (!resetn_in)
			s_ff <= '0;
		else
			s_ff <= nxt_s;
	end

	assign expire_out = s_ff.expire;

	a_timer_span: assert property ( // R4
		@(posedge core_clk_in) disable iff (!resetn_in)
		$rose(s_ff.expire) |-> s_ff.ticks ==
			((s_ff.tgt == '0 ? 32'h1 : 32'(s_ff.tgt)) * 32'(s_ff.lim)))
		else $error("timeout length differs from scaled event period");
	a_timer_off: assert property ( // R3
		@(posedge core_clk_in) disable iff (!resetn_in)
		(start_in && rx_time_in == rxt_pkg::RX_TIME_OFF) |=>
			!s_ff.active [*2])
		else $error("disabled timeout still counting");
	a_msb_target: assert property ( // R7
		@(posedge core_clk_in) disable iff (!resetn_in)
		start_in && rx_time_in == 3'h0 |=>
			s_ff.tgt == ($past(event_period_in) >> 3))
		else $error("setting 0 does not keep the 13 upper bits");

endmodule : rxt_rx_timer

/* core/rxt_core.sv */
// Radio state machine control: RX timeout, clear channel and off states
// Summary of operation
// R1: Carrier-sense bit ends RX; ASK/OOK ends if no carrier in 8 symbols.
// R2: At timeout keep RX on sync, or on sync or preamble quality when set.
// R3: Three-bit timeout field, reset 7; value 7 means no timeout.
// R4: Timeout length is event period scaled by setting and resolution.
// R5: Software keeps wake timer resolution at 0 or 1 with wake-on-radio.
// R6: Software enables the RC oscillator before using settings 0 to 6.
// R7: Counter uses 13 upper event bits at 0, one fewer per step.
// R8: Clear-channel select, reset 3, picks always, RSSI, not receiving, both.
// R9: After-receive field, reset 0: idle, synth on, transmit, stay receive.
// R10: Software avoids transmit or synth-on after receive with clear channel.
// R11: After-transmit field, reset 0: idle, synth on, stay transmit, receive.
// R12: Deviation applies in FSK/GFSK receive; none in MSK/ASK/OOK receive.
// R13: Unused upper bits of both control registers read zero, ignore writes.
`timescale 1ns/1ps
module rxt_core (
	input  wire logic                  core_clk_in,
	input  wire logic                  resetn_in,
	input  wire logic                  hsel_in,
	input  wire logic [31:0]           haddr_in,
	input  wire logic [1:0]            htrans_in,
	input  wire logic                  hwrite_in,
	input  wire logic [2:0]            hsize_in,
	input  wire logic [31:0]           hwdata_in,
	input  wire logic                  hready_in,
	output logic [31:0]                hrdata_out,
	output logic                       hreadyout_out,
	output logic                       hresp_out,
	input  wire rxt_pkg::rxt_radio_in_s radio_in,
	output rxt_pkg::rxt_state_e        radio_state_out,
	output logic                       next_state_valid_out,
	output logic                       rx_end_out,
	output logic                       clear_channel_out,
	output logic                       dev_active_out,
	output logic [2:0]                 dev_exp_out,
	output logic [2:0]                 dev_mant_out
);

	rxt_pkg::rxt_core_s s_ff, nxt_s;
	logic               rx_enter;
	logic               timer_expire;
	logic [7:0]         status;

	// Map an off-mode code onto the next radio state
	function automatic rxt_pkg::rxt_state_e off_state(input logic [1:0] code);
		unique case (code)
			2'h0: off_state = rxt_pkg::ST_IDLE;
			2'h1: off_state = rxt_pkg::ST_SYNTH_ON_READY_STATE;
			2'h2: off_state = rxt_pkg::ST_TX;
			2'h3: off_state = rxt_pkg::ST_RX;
		endcase
	endfunction : off_state

	// R8: clear channel modes
	function automatic logic cca_calc(input logic [1:0] sel, input logic cs,
		input logic rx_pkt);
		unique case (sel)
			2'h0: cca_calc = 1'b1;
			2'h1: cca_calc = !cs;
			2'h2: cca_calc = !rx_pkt;
			2'h3: cca_calc = !cs && !rx_pkt;
		endcase
	endfunction : cca_calc

	// Apply a register write to the configuration image
	function automatic rxt_pkg::rxt_cfg_s wr_cfg(input logic [7:0] idx,
		input rxt_pkg::rxt_cfg_s c, input logic [31:0] d);
		wr_cfg = c;
		// R13: upper bits dropped
		unique case (idx)
			rxt_pkg::IDX_RX_TIMEOUT: begin
				wr_cfg.carrier_sense_rx_end  = d[rxt_pkg::RXT_RSSI_POS];
				wr_cfg.timeout_quality_check = d[rxt_pkg::RXT_QUAL_POS];
				wr_cfg.rx_time = d[rxt_pkg::RXT_TIME_POS +: 3];
			end
			rxt_pkg::IDX_PACKET_END: begin
				wr_cfg.clear_channel_select = d[rxt_pkg::PE_CCA_POS +: 2];
				wr_cfg.after_receive_state  = d[rxt_pkg::PE_RXOFF_POS +: 2];
				wr_cfg.after_transmit_state = d[rxt_pkg::PE_TXOFF_POS +: 2];
			end
			rxt_pkg::IDX_DEVIATION: begin
				wr_cfg.dev_e = d[rxt_pkg::DEV_E_POS +: 3];
				wr_cfg.dev_m = d[rxt_pkg::DEV_M_POS +: 3];
			end
			rxt_pkg::IDX_RADIO_CFG: begin
				wr_cfg.wake_event_period = d[rxt_pkg::CFG_EVENT_POS +: 16];
				wr_cfg.wake_timer_resolution = d[rxt_pkg::CFG_RES_POS +: 2];
				wr_cfg.modulation =
					rxt_pkg::rxt_mod_e'(d[rxt_pkg::CFG_MOD_POS +: 2]);
			end
			default: wr_cfg = c;
		endcase
	endfunction : wr_cfg

	// Build the read word of one register
	function automatic logic [31:0] rd_word(input logic [7:0] idx,
		input rxt_pkg::rxt_cfg_s c, input logic [7:0] st);
		rd_word = 32'h0;
		// R13: unused bits read zero
		unique case (idx)
			rxt_pkg::IDX_RX_TIMEOUT: begin
				rd_word[rxt_pkg::RXT_RSSI_POS] = c.carrier_sense_rx_end;
				rd_word[rxt_pkg::RXT_QUAL_POS] = c.timeout_quality_check;
				rd_word[rxt_pkg::RXT_TIME_POS +: 3] = c.rx_time;
			end
			rxt_pkg::IDX_PACKET_END: begin
				rd_word[rxt_pkg::PE_CCA_POS +: 2] = c.clear_channel_select;
				rd_word[rxt_pkg::PE_RXOFF_POS +: 2] = c.after_receive_state;
				rd_word[rxt_pkg::PE_TXOFF_POS +: 2] = c.after_transmit_state;
			end
			rxt_pkg::IDX_DEVIATION: begin
				rd_word[rxt_pkg::DEV_E_POS +: 3] = c.dev_e;
				rd_word[rxt_pkg::DEV_M_POS +: 3] = c.dev_m;
			end
			rxt_pkg::IDX_RADIO_CFG: begin
				rd_word[rxt_pkg::CFG_EVENT_POS +: 16] = c.wake_event_period;
				rd_word[rxt_pkg::CFG_RES_POS +: 2] = c.wake_timer_resolution;
				rd_word[rxt_pkg::CFG_MOD_POS +: 2] = c.modulation;
			end
			rxt_pkg::IDX_STATUS: rd_word[7:0] = st;
			default: rd_word = 32'h0;
		endcase
	endfunction : rd_word

	// Status word shows the live state of the block
	always_comb begin
		status = 8'h0;
		status[rxt_pkg::ST_STATE_POS +: 2] = s_ff.rstate;
		status[rxt_pkg::ST_CCA_POS]  = s_ff.cca;
		status[rxt_pkg::ST_CS_POS]   = s_ff.cs_seen;
		status[rxt_pkg::ST_SYNC_POS] = s_ff.sync_seen;
		status[rxt_pkg::ST_TOUT_POS] = s_ff.tout_seen;
	end

	// Bus slave and radio state machine
	always_comb begin
		logic keep;
		logic ask_fail;
		logic cs_drop;
		logic addr_ok;
		keep = 1'b0;
		ask_fail = 1'b0;
		cs_drop = 1'b0;
		addr_ok = (haddr_in[31:10] == 22'h0);
		nxt_s = s_ff;
		rx_enter = 1'b0;
		nxt_s.rx_end = 1'b0;
		nxt_s.nxt_valid = 1'b0;
		nxt_s.ready = 1'b1;
		// Data phase write lands before a following read is answered
		if (s_ff.dp_wr)
			nxt_s.cfg = wr_cfg(s_ff.dp_idx, s_ff.cfg, hwdata_in);
		nxt_s.dp_wr = 1'b0;
		nxt_s.dp_rd = 1'b0;
		if (hsel_in && hready_in && htrans_in[1]) begin
			nxt_s.dp_idx = haddr_in[9:2];
			nxt_s.dp_wr = hwrite_in && addr_ok && hsize_in == rxt_pkg::HSIZE_WORD;
			nxt_s.dp_rd = !hwrite_in;
			if (!hwrite_in)
				nxt_s.hrdata = addr_ok ?
					rd_word(haddr_in[9:2], nxt_s.cfg, status) : 32'h0;
		end

		unique case (s_ff.rstate)
			rxt_pkg::ST_IDLE, rxt_pkg::ST_SYNTH_ON_READY_STATE: begin
				if (radio_in.rx_start) begin
					nxt_s.rstate = rxt_pkg::ST_RX;
					rx_enter = 1'b1;
				end else if (radio_in.tx_start) begin
					nxt_s.rstate = rxt_pkg::ST_TX;
				end
			end
			rxt_pkg::ST_RX: begin
				if (radio_in.symbol_tick && s_ff.sym_cnt != rxt_pkg::ASK_SYMBOLS)
					nxt_s.sym_cnt = s_ff.sym_cnt + 4'h1;
				nxt_s.cs_seen = s_ff.cs_seen | radio_in.carrier_sense;
				nxt_s.sync_seen = s_ff.sync_seen | radio_in.sync_found;
				// R2: quality check
				keep = nxt_s.sync_seen || (s_ff.cfg.timeout_quality_check &&
					radio_in.preamble_quality_flag);
				// R1: ASK carrier window
				ask_fail = s_ff.cfg.carrier_sense_rx_end &&
					s_ff.cfg.modulation == rxt_pkg::MOD_ASK &&
					s_ff.sym_cnt == rxt_pkg::ASK_SYMBOLS && !nxt_s.cs_seen;
				// R1: carrier lost ends RX
				cs_drop = s_ff.cfg.carrier_sense_rx_end &&
					s_ff.cfg.modulation != rxt_pkg::MOD_ASK && s_ff.cs_seen &&
					!radio_in.carrier_sense && !radio_in.receiving_pkt &&
					!nxt_s.sync_seen;
				if (radio_in.pkt_rx_done) begin
					// R9: after-receive state
					nxt_s.rstate = off_state(s_ff.cfg.after_receive_state);
					nxt_s.nxt_valid = 1'b1;
					rx_enter = (nxt_s.rstate == rxt_pkg::ST_RX);
				end else if ((timer_expire && !keep) || ask_fail || cs_drop) begin
					nxt_s.rstate = rxt_pkg::ST_IDLE;
					nxt_s.rx_end = 1'b1;
					nxt_s.tout_seen = 1'b1;
				end
			end
			rxt_pkg::ST_TX: begin
				if (radio_in.pkt_tx_done) begin
					// R11: after-transmit state
					nxt_s.rstate = off_state(s_ff.cfg.after_transmit_state);
					nxt_s.nxt_valid = 1'b1;
					rx_enter = (nxt_s.rstate == rxt_pkg::ST_RX);
				end
			end
		endcase

		// Idle command overrides every transition
		if (radio_in.idle_cmd) begin
			nxt_s.rstate = rxt_pkg::ST_IDLE;
			rx_enter = 1'b0;
		end
		// Fresh RX attempt clears the search flags
		if (rx_enter) begin
			nxt_s.sym_cnt = 4'h0;
			nxt_s.cs_seen = 1'b0;
			nxt_s.sync_seen = 1'b0;
			nxt_s.tout_seen = 1'b0;
		end

		// R8: clear channel output
		nxt_s.cca = cca_calc(s_ff.cfg.clear_channel_select,
			radio_in.carrier_sense, radio_in.receiving_pkt);
		// R12: deviation use
		unique case (nxt_s.rstate)
			rxt_pkg::ST_RX: nxt_s.dev_active =
				s_ff.cfg.modulation == rxt_pkg::MOD_2FSK ||
				s_ff.cfg.modulation == rxt_pkg::MOD_GFSK;
			rxt_pkg::ST_TX: nxt_s.dev_active =
				s_ff.cfg.modulation != rxt_pkg::MOD_ASK;
			default: nxt_s.dev_active = 1'b0;
		endcase
	end

	// State register
	always_ff @(posedge core_clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			s_ff <= '0;
			s_ff.cfg <= rxt_pkg::CFG_RST;
			s_ff.rstate <= rxt_pkg::ST_IDLE;
			s_ff.cca <= 1'b1;
		end else begin
			s_ff <= nxt_s;
		end
	end

	// Sync-search timeout counter
	rxt_rx_timer #(
		.EVENT_W (16)
	) u_timer (
		.core_clk_in     (core_clk_in),
		.resetn_in       (resetn_in),
		.start_in        (rx_enter),
		.run_in          (nxt_s.rstate == rxt_pkg::ST_RX),
		.rc_tick_in      (radio_in.rc_tick),
		.event_period_in (s_ff.cfg.wake_event_period),
		.rx_time_in      (s_ff.cfg.rx_time),
		.res_in          (s_ff.cfg.wake_timer_resolution),
		.expire_out      (timer_expire)
	);

	// Outputs straight from the state register, except hresp_out tied to 0
	assign hrdata_out           = s_ff.hrdata;
	assign hreadyout_out        = s_ff.ready;
	assign hresp_out            = 1'b0;
	assign radio_state_out      = s_ff.rstate;
	assign next_state_valid_out = s_ff.nxt_valid;
	assign rx_end_out           = s_ff.rx_end;
	assign clear_channel_out    = s_ff.cca;
	assign dev_active_out       = s_ff.dev_active;
	assign dev_exp_out          = s_ff.cfg.dev_e;
	assign dev_mant_out         = s_ff.cfg.dev_m;

	default clocking cb @(posedge core_clk_in);
	endclocking
	default disable iff (!resetn_in);

	a_ask_window: assert property ( // R1
		s_ff.rstate == rxt_pkg::ST_RX && s_ff.cfg.carrier_sense_rx_end &&
		s_ff.cfg.modulation == rxt_pkg::MOD_ASK &&
		s_ff.sym_cnt == rxt_pkg::ASK_SYMBOLS && !s_ff.cs_seen &&
		!radio_in.carrier_sense && !radio_in.pkt_rx_done &&
		!radio_in.idle_cmd |=> rx_end_out && radio_state_out == rxt_pkg::ST_IDLE)
		else $error("ASK RX did not end without carrier in 8 symbols");
	a_sync_keep: assert property ( // R2
		s_ff.rstate == rxt_pkg::ST_RX && timer_expire &&
		!s_ff.cfg.carrier_sense_rx_end &&
		(s_ff.sync_seen || radio_in.sync_found) |=> !rx_end_out)
		else $error("RX ended although sync was found");
	a_qual_end: assert property ( // R2
		s_ff.rstate == rxt_pkg::ST_RX && timer_expire && !s_ff.sync_seen &&
		!radio_in.sync_found && !radio_in.pkt_rx_done && !radio_in.idle_cmd &&
		!(s_ff.cfg.timeout_quality_check && radio_in.preamble_quality_flag)
		|=> rx_end_out ##1 !rx_end_out)
		else $error("timeout without sync did not end RX");
	a_rx_off: assert property ( // R9
		s_ff.rstate == rxt_pkg::ST_RX && radio_in.pkt_rx_done &&
		!radio_in.idle_cmd |=> next_state_valid_out &&
		radio_state_out == off_state($past(s_ff.cfg.after_receive_state)))
		else $error("wrong state after packet received");
	a_tx_off: assert property ( // R11
		s_ff.rstate == rxt_pkg::ST_TX && radio_in.pkt_tx_done &&
		!radio_in.idle_cmd |=> next_state_valid_out &&
		radio_state_out == off_state($past(s_ff.cfg.after_transmit_state)))
		else $error("wrong state after packet sent");
	a_clear_channel_select: assert property ( // R8
		1'b1 |=> clear_channel_out ==
		cca_calc($past(s_ff.cfg.clear_channel_select),
		$past(radio_in.carrier_sense), $past(radio_in.receiving_pkt)))
		else $error("clear channel output disagrees with mode");
	a_dev_unused: assert property ( // R12
		radio_state_out == rxt_pkg::ST_RX &&
		($past(s_ff.cfg.modulation) == rxt_pkg::MOD_ASK ||
		$past(s_ff.cfg.modulation) == rxt_pkg::MOD_MSK) |-> !dev_active_out)
		else $error("deviation applied in MSK or ASK receive");
	a_unused_zero: assert property ( // R13
		s_ff.dp_rd && (s_ff.dp_idx == rxt_pkg::IDX_RX_TIMEOUT ||
		s_ff.dp_idx == rxt_pkg::IDX_PACKET_END) |-> hrdata_out[31:6] == 26'h0 &&
		(s_ff.dp_idx != rxt_pkg::IDX_RX_TIMEOUT || !hrdata_out[5]))
		else $error("unused control bits read nonzero");

endmodule : rxt_core

/* tb/testbench.sv */
// Self-checking bench for the radio control block over its AHB-Lite port
`timescale 1ns/1ps
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin err_total++; \
	$display("unexpected t=%0t got=%h exp=%h", $time, g, e); end end
module testbench;
	logic                   clk, rstn, hsel, hwrite, pv, rd_dp, hrdy;
	logic [31:0]            haddr, hwdata, hrdata, rs, cfg, re;
	logic [1:0]             htrans, ex_st;
	logic [2:0]             hsize;
	logic                   nsv, rxe, cca, dev, ex_cca, ex_dev, hresp;
	logic [3:0]             end_cnt = '0, nsv_cnt = '0, ex_end, ex_nsv;
	logic [5:0]             devf, ex_devf;
	logic [18:0]            obs;
	logic [37:0]            pe;
	logic [12:0]            t;
	logic [37:0]            pexp_q[$];
	logic [31:0]            rexp_q[$];
	rxt_pkg::rxt_radio_in_s rin;
	rxt_pkg::rxt_state_e    st;
	int                     err_total, checks_done, tl;
	// Timeout cases: [12] ends, [11] pqi, [10] sync, [9] ask, [8] res, rxt
	logic [12:0] tc [7] = '{13'h1002, 13'h1102, 13'h0402, 13'h080A,
		13'h1802, 13'h0007, 13'h1217};

	rxt_core rxt_core_inst (
		.core_clk_in         (clk),
		.resetn_in           (rstn),
		.hsel_in             (hsel),
		.haddr_in            (haddr),
		.htrans_in           (htrans),
		.hwrite_in           (hwrite),
		.hsize_in            (hsize),
		.hwdata_in           (hwdata),
		.hready_in           (hrdy),
		.hrdata_out          (hrdata),
		.hreadyout_out       (hrdy),
		.hresp_out           (hresp),
		.radio_in            (rin),
		.radio_state_out     (st),
		.next_state_valid_out(nsv),
		.rx_end_out          (rxe),
		.clear_channel_out   (cca),
		.dev_active_out      (dev),
		.dev_exp_out         (devf[5:3]),
		.dev_mant_out        (devf[2:0])
	);

	// Observed port word: state, clear, deviation use, pulse counts
	assign obs = {hresp, devf, st, cca, dev, end_cnt, nsv_cnt};

	// 250 MHz clock
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end

	// Monitor: counts pulses and compares results with the oldest note
	always @(posedge clk) begin
		if (rxe === 1'b1) end_cnt <= end_cnt + 4'h1;
		if (nsv === 1'b1) nsv_cnt <= nsv_cnt + 4'h1;
		if (rd_dp === 1'b1 && hrdy === 1'b1) begin
			re = rexp_q.pop_front();
			`CHK(hrdata, re)
		end
		if (pv === 1'b1) begin
			pe = pexp_q.pop_front();
			`CHK(obs & pe[18:0], pe[37:19] & pe[18:0])
		end
	end

	task end_sim();
		$display("checks %0d errors %0d", checks_done, err_total);
		if (err_total == 0 && checks_done > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask : end_sim

	task tmo();
		err_total++;
		$display("unexpected t=%0t got=%h exp=%h", $time, 1'b0, 1'b1);
		end_sim();
	endtask : tmo

	function logic [31:0] xs(input logic [31:0] v);
		logic [31:0] x;
		x = v ^ (v << 13);
		x = x ^ (x >> 17);
		return x ^ (x << 5);
	endfunction : xs

	function logic [31:0] adr(input logic [7:0] i);
		return {22'h0, i, 2'h0};
	endfunction : adr

	// Waits for an edge with hready high, bounded
	task hw();
		int n;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (hrdy !== 1'b1 && n < 50);
		if (hrdy !== 1'b1) tmo();
	endtask : hw

	// One single word transfer: address phase, then data phase
	task ahb(input logic w, input logic [31:0] a, input logic [31:0] d);
		hsel   <= 1'b1;
		haddr  <= a;
		htrans <= 2'h2;
		hwrite <= w;
		hsize  <= rxt_pkg::HSIZE_WORD;
		hw();
		hsel   <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		rd_dp  <= ~w;
		hw();
		rd_dp  <= 1'b0;
	endtask : ahb

	task wreg(input logic [7:0] i, input logic [31:0] d);
		ahb(1'b1, adr(i), d);
	endtask : wreg

	task rreg(input logic [31:0] a, input logic [31:0] e);
		rexp_q.push_back(e);
		ahb(1'b0, a, 32'h0);
	endtask : rreg

	// Notes the expected port word and asks the monitor to compare
	task pchk(input logic [18:0] mk);
		@(posedge clk);
		pexp_q.push_back({1'b0, ex_devf, ex_st, ex_cca, ex_dev, ex_end,
			ex_nsv, mk});
		pv <= 1'b1;
		@(posedge clk);
		pv <= 1'b0;
	endtask : pchk

	task lvl(input logic [10:0] m, input logic v);
		rin <= rxt_pkg::rxt_radio_in_s'(v ? (rin | m) : (rin & ~m));
		@(posedge clk);
	endtask : lvl

	task rpulse(input logic [10:0] m);
		rin <= rxt_pkg::rxt_radio_in_s'(rin | m);
		@(posedge clk);
		rin <= rxt_pkg::rxt_radio_in_s'(rin & ~m);
		// Let the clear land before the next caller touches rin
		@(posedge clk);
	endtask : rpulse

	task wait_st(input rxt_pkg::rxt_state_e s);
		int n;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (st !== s && n < 300);
		if (st !== s) tmo();
	endtask : wait_st

	// Main sequence
	initial begin
		{hsel, hwrite, rd_dp, pv, htrans, hsize} = '0;
		{haddr, hwdata} = '0;
		rin = '0;
		{ex_end, ex_nsv, ex_st, ex_dev} = '0;
		ex_devf = {rxt_pkg::DEV_E_RST, rxt_pkg::DEV_M_RST};
		ex_cca = 1'b1;
		err_total = 0;
		checks_done = 0;
		rs = 32'hb3f65090;
		rstn = 1'b0;
		repeat (5) @(posedge clk);
		rstn <= 1'b1;
		repeat (2) @(posedge clk);
		rreg(adr(rxt_pkg::IDX_RX_TIMEOUT), 32'h07);
		rreg(adr(rxt_pkg::IDX_PACKET_END), 32'h30);
		rreg(adr(rxt_pkg::IDX_DEVIATION), 32'h47);
		rreg(32'h200, 32'h0);
		for (int i = 0; i < 4; i++) begin
			rs = xs(rs);
			wreg(rxt_pkg::IDX_RX_TIMEOUT, rs);
			rreg(adr(rxt_pkg::IDX_RX_TIMEOUT), rs & 32'h1F);
			wreg(rxt_pkg::IDX_PACKET_END, rs);
			rreg(adr(rxt_pkg::IDX_PACKET_END), rs & 32'h3F);
		end
		wreg(rxt_pkg::IDX_DEVIATION, rs);
		rreg(adr(rxt_pkg::IDX_DEVIATION), rs & 32'h77);
		ex_devf = {rs[6:4], rs[2:0]};
		pchk(19'h7F000);
		wreg(rxt_pkg::IDX_RX_TIMEOUT, 32'h07);
		// every clear-channel mode against carrier and receive levels
		for (int m = 0; m < 4; m++) begin
			for (int c = 0; c < 4; c++) begin
				wreg(rxt_pkg::IDX_PACKET_END, m << 4);
				rin <= rxt_pkg::rxt_radio_in_s'((rin & ~11'h00C)
					| {7'h0, c[0], c[1], 2'h0});
				@(posedge clk);
				ex_cca = !((m[0] && c[0]) || (m[1] && c[1]));
				pchk(19'h00EFF);
			end
		end
		lvl(11'h00C, 1'b0);
		// every state after receive and after transmit
		for (int k = 0; k < 4; k++) begin
			wreg(rxt_pkg::IDX_PACKET_END, k << 2);
			rpulse(11'h400);
			rpulse(11'h080);
			ex_st = 2'(k);
			ex_nsv++;
			pchk(19'h00CFF);
			rpulse(11'h100);
			wreg(rxt_pkg::IDX_PACKET_END, k);
			rpulse(11'h200);
			rpulse(11'h040);
			ex_nsv++;
			pchk(19'h00CFF);
			rpulse(11'h100);
			ex_st = 2'h0;
		end
		lvl(11'h003, 1'b1);
		for (int j = 0; j < 7; j++) begin
			t = tc[j];
			cfg = 32'h100 | {15'h0, t[8], 16'h0} | {10'h0, t[9], 21'h0};
			wreg(rxt_pkg::IDX_RADIO_CFG, cfg);
			wreg(rxt_pkg::IDX_RX_TIMEOUT, {24'h0, t[7:0]});
			lvl(11'h010, t[11]);
			rpulse(11'h400);
			if (t[10]) rpulse(11'h020);
			ex_st = 2'h3;
			ex_dev = !t[9];
			tl = t[8] ? 40 : 8;
			// Look one cycle before the timeout ends the search
			repeat (tl - 3) @(posedge clk);
			pchk(19'h00DFF);
			if (t[12]) begin
				wait_st(rxt_pkg::ST_IDLE);
				ex_st = 2'h0;
				ex_end++;
				pchk(19'h00CFF);
				rreg(adr(rxt_pkg::IDX_STATUS), 32'h90);
			end else begin
				repeat (80) @(posedge clk);
				pchk(19'h00CFF);
				rpulse(11'h100);
				ex_st = 2'h0;
			end
		end
		// carrier loss ends receive, MSK deviation use
		wreg(rxt_pkg::IDX_RADIO_CFG, 32'h300100);
		rpulse(11'h400);
		ex_st = 2'h3;
		ex_dev = 1'b0;
		pchk(19'h00DFF);
		lvl(11'h008, 1'b1);
		lvl(11'h008, 1'b0);
		ex_st = 2'h0;
		ex_end++;
		pchk(19'h00CFF);
		rreg(adr(rxt_pkg::IDX_STATUS), 32'hB0);
		rpulse(11'h200);
		ex_st = 2'h2;
		ex_dev = 1'b1;
		pchk(19'h00DFF);
		rpulse(11'h100);
		end_sim();
	end
endmodule : testbench
